//--- include/tap_map.vh
// constants for the boundary-scan test access port controller
// Notes on behaviour
// R1: sample on rising edge, drive on falling
// R2: controller watches test clock and mode-select only
// R3: state advances on each rising edge
// R4: sixteen states, six stable, ten transient
// R5: separate data and instruction paths, one active
// R6: serial data enters selected register
// R7: serial data leaves selected register
// R8: instruction register is eight bits
// R9: boundary register 44 bits, control 3 bits
// R10: bypass one bit, identification 32 bits
// R11: power-up starts in test-logic-reset
// R12: test logic held inactive in reset state
// R13: mode-select high five cycles forces reset
// R14: instruction resets to identification code
// R15: output-control boundary cells clear on reset
// R16: boundary-control resets to signature compaction
// R17: leave reset only through run-test/idle
// R18: run-test/idle is stable, reachable after scans
// R19: selected test runs only in run-test/idle
// R20: scan-select states act nothing, exit next cycle
// R21: cleared cells are boundary bits 43 to 40
// R22: output enables on falling edge in shift
// R23: new instruction takes effect on falling edge
// R24: output floats on falling edge after exit1
// R25: transitions follow the standard state graph
`ifndef TAP_MAP_VH
`define TAP_MAP_VH
`define IR_RESET_VALUE   8'h81
`define IR_CAPTURE_VALUE 8'h81
`define BCR_RESET_VALUE  3'h2
`define BSR_OE_HI        43
`define BSR_OE_LO        40
`define OP_BYPASS        8'hff
`define OP_IDCODE        8'h81
`define OP_SAMPLE        8'h82
`define OP_EXTEST        8'h00
`define OP_BCR_SCAN      8'h0e
`define OP_RUN_T         8'h09
`endif

//--- logic/scan_tap.v
// boundary-scan test access port controller and test registers
`timescale 1ns/1ps
`default_nettype none
`include "tap_map.vh"
module scan_tap #(
  parameter BSR_W = 44,
  parameter BCR_W = 3,
  parameter [31:0] ID_CODE = 32'h00000001 // arbitrary value
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             tck,
  input  wire             tms,
  input  wire             tdi,
  output reg              tdo_out,
  output reg              tdo_oe_n,
  input  wire [BSR_W-1:0] bsr_capture,
  output reg  [BSR_W-1:0] bsr_update,
  output reg  [7:0]       instruction,
  output reg  [BCR_W-1:0] bcr_update,
  output wire             test_logic_reset,
  output wire             run_test_active,
  output wire             bsr_run_step
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDR = 16'h0004,
                    S_CDR = 16'h0008, S_SHD = 16'h0010, S_E1D = 16'h0020,
                    S_PDR = 16'h0040, S_E2D = 16'h0080, S_UDR = 16'h0100,
                    S_SIR = 16'h0200, S_CIR = 16'h0400, S_SHI = 16'h0800,
                    S_E1I = 16'h1000, S_PIR = 16'h2000, S_E2I = 16'h4000,
                    S_UIR = 16'h8000;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  reg [1:0] tck_sync_reg;
  reg [1:0] tms_sync_reg;
  reg [1:0] tdi_sync_reg;
  reg       tck_last_reg;
  always @(posedge clock) begin
    if (rst) begin
      tck_sync_reg <= 2'h0;
      tms_sync_reg <= 2'h3;
      tdi_sync_reg <= 2'h3;
      tck_last_reg <= 1'b0;
    end else begin
      tck_sync_reg <= {tck_sync_reg[0], tck};
      tms_sync_reg <= {tms_sync_reg[0], tms};
      tdi_sync_reg <= {tdi_sync_reg[0], tdi};
      tck_last_reg <= tck_sync_reg[1];
    end
  end
  // only the test clock and mode-select steer the machine
  wire rise = tck_sync_reg[1] & ~tck_last_reg; // R1 R2
  wire fall = ~tck_sync_reg[1] & tck_last_reg; // R1
  wire tms_s = tms_sync_reg[1];
  wire tdi_s = tdi_sync_reg[1];

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  reg [15:0] state_reg;
  reg [15:0] state_next;
  always @* begin
    case (state_reg) // R4 R25
      S_TLR: state_next = tms_s ? S_TLR : S_RTI; // R17
      S_RTI: state_next = tms_s ? S_SDR : S_RTI; // R18
      S_SDR: state_next = tms_s ? S_SIR : S_CDR; // R20
      S_CDR: state_next = tms_s ? S_E1D : S_SHD;
      S_SHD: state_next = tms_s ? S_E1D : S_SHD;
      S_E1D: state_next = tms_s ? S_UDR : S_PDR;
      S_PDR: state_next = tms_s ? S_E2D : S_PDR;
      S_E2D: state_next = tms_s ? S_UDR : S_SHD;
      S_UDR: state_next = tms_s ? S_SDR : S_RTI;
      S_SIR: state_next = tms_s ? S_TLR : S_CIR; // R20 R13
      S_CIR: state_next = tms_s ? S_E1I : S_SHI;
      S_SHI: state_next = tms_s ? S_E1I : S_SHI;
      S_E1I: state_next = tms_s ? S_UIR : S_PIR;
      S_PIR: state_next = tms_s ? S_E2I : S_PIR;
      S_E2I: state_next = tms_s ? S_UIR : S_SHI;
      S_UIR: state_next = tms_s ? S_SDR : S_RTI;
      default: state_next = S_TLR;
    endcase
  end
  always @(posedge clock) begin
    if (rst)
      state_reg <= S_TLR; // R11
    else if (rise)
      state_reg <= state_next; // R3
  end

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  // unsupported opcodes fall back to bypass
  localparam [3:0] SEL_BYP = 4'h1, SEL_ID = 4'h2, SEL_BSR = 4'h4, SEL_BCR = 4'h8;
  reg [3:0] sel;
  always @* begin
    case (instruction)
      `OP_IDCODE:  sel = SEL_ID;
      `OP_SAMPLE:  sel = SEL_BSR;
      `OP_EXTEST:  sel = SEL_BSR;
      `OP_BCR_SCAN: sel = SEL_BCR;
      `OP_RUN_T:   sel = SEL_BYP;
      default:     sel = SEL_BYP;
    endcase
  end

  // ---------------------------------------------------------------
  // shift registers
  // ---------------------------------------------------------------
  reg [7:0]       ir_sh_reg;  // R8
  reg [BSR_W-1:0] bsr_sh_reg; // R9
  reg [BCR_W-1:0] bcr_sh_reg; // R9
  reg             byp_sh_reg; // R10
  reg [31:0]      id_sh_reg;  // R10
  wire in_tlr = (state_reg == S_TLR);
  always @(posedge clock) begin
    if (rst) begin
      ir_sh_reg  <= `IR_RESET_VALUE;
      bsr_sh_reg <= {BSR_W{1'b0}};
      bcr_sh_reg <= `BCR_RESET_VALUE;
      byp_sh_reg <= 1'b0;
      id_sh_reg  <= 32'h00000000;
    end else if (rise) begin
      if (state_reg == S_CIR)
        ir_sh_reg <= `IR_CAPTURE_VALUE;
      else if (state_reg == S_SHI)
        ir_sh_reg <= {tdi_s, ir_sh_reg[7:1]}; // R5 R6
      if (state_reg == S_CDR) begin
        case (sel)
          SEL_ID:  id_sh_reg <= ID_CODE;
          SEL_BSR: bsr_sh_reg <= bsr_capture;
          SEL_BCR: bcr_sh_reg <= bcr_update;
          default: byp_sh_reg <= 1'b0;
        endcase
      end else if (state_reg == S_SHD) begin
        case (sel) // R6
          SEL_ID:  id_sh_reg <= {tdi_s, id_sh_reg[31:1]};
          SEL_BSR: bsr_sh_reg <= {tdi_s, bsr_sh_reg[BSR_W-1:1]};
          SEL_BCR: bcr_sh_reg <= {tdi_s, bcr_sh_reg[BCR_W-1:1]};
          default: byp_sh_reg <= tdi_s;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // update latches and serial output, changed on falling edges; latches also loaded while in test-logic-reset
  // ---------------------------------------------------------------
  reg shift_out;
  always @* begin
    if (state_reg == S_SHI)
      shift_out = ir_sh_reg[0];
    else case (sel) // R7
      SEL_ID:  shift_out = id_sh_reg[0];
      SEL_BSR: shift_out = bsr_sh_reg[0];
      SEL_BCR: shift_out = bcr_sh_reg[0];
      default: shift_out = byp_sh_reg;
    endcase
  end
  always @(posedge clock) begin
    if (rst) begin
      instruction <= `IR_RESET_VALUE; // R14
      bcr_update  <= `BCR_RESET_VALUE; // R16
      bsr_update  <= {BSR_W{1'b0}};
      tdo_out     <= 1'b0;
      tdo_oe_n    <= 1'b1;
    end else begin
      // reset is held as a level, so a forced reset leaves no stale instruction behind
      if (in_tlr) begin
        instruction <= `IR_RESET_VALUE; // R14
        bcr_update  <= `BCR_RESET_VALUE; // R16
        bsr_update[`BSR_OE_HI:`BSR_OE_LO] <= 4'h0; // R15 R21
      end else if (fall && state_reg == S_UIR)
        instruction <= ir_sh_reg; // R23
      else if (fall && state_reg == S_UDR) begin
        if (sel == SEL_BSR)
          bsr_update <= bsr_sh_reg;
        if (sel == SEL_BCR)
          bcr_update <= bcr_sh_reg;
      end
      if (fall) begin
        if (state_reg == S_SHD || state_reg == S_SHI) begin
          tdo_out  <= shift_out; // R22 R7
          tdo_oe_n <= 1'b0; // R22
        end else
          tdo_oe_n <= 1'b1; // R24
      end
    end
  end

  // ---------------------------------------------------------------
  // test activity
  // ---------------------------------------------------------------
  assign test_logic_reset = in_tlr; // R12
  assign run_test_active  = (state_reg == S_RTI) & (instruction == `OP_RUN_T); // R19
  assign bsr_run_step     = run_test_active & rise; // R19
endmodule // scan_tap
`default_nettype wire

//--- testbench/scan_tap_properties.sv
// assertions on the test access port controller outputs
`timescale 1ns/1ps
`default_nettype none
module scan_tap_props #(
  parameter BSR_W = 44
) (
  input wire logic             clock,
  input wire logic             rst,
  input wire logic             tck,
  input wire logic             tms,
  input wire logic             tdo_oe_n,
  input wire logic [BSR_W-1:0] bsr_update,
  input wire logic [7:0]       instruction,
  input wire logic [2:0]       bcr_update,
  input wire logic             test_logic_reset,
  input wire logic             run_test_active,
  input wire logic             bsr_run_step
);
  logic       tck_reg;
  logic [2:0] high_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // rises of the test clock with mode-select high, held at five
  always_ff @(posedge clock) begin
    tck_reg <= tck;
    if (rst || (tck && !tck_reg && !tms)) high_reg <= 3'h0;
    else if (tck && !tck_reg && high_reg != 3'h5) high_reg <= high_reg + 3'h1;
  end
  rst_values_a: assert property (
    $fell(rst) |-> instruction == 8'h81 && bcr_update == 3'h2) else $error("reset value");
  reset_instr_a: assert property (
    test_logic_reset [*2] |-> instruction == 8'h81 && bcr_update == 3'h2) else $error("tlr");
  drive_cells_a: assert property (
    test_logic_reset [*2] |-> bsr_update[43:40] == 4'h0) else $error("drive cells");
  reset_quiet_a: assert property (
    test_logic_reset |-> tdo_oe_n && !run_test_active && !bsr_run_step) else $error("quiet");
  step_idle_a: assert property (
    bsr_run_step |-> run_test_active) else $error("step outside idle");
  step_pulse_a: assert property (
    bsr_run_step |=> !bsr_run_step) else $error("step width");
  five_high_a: assert property (
    high_reg == 3'h5 |-> ##[0:8] test_logic_reset) else $error("no forced reset");
  drive_shift_a: assert property (
    !tdo_oe_n |-> !test_logic_reset && !run_test_active) else $error("drive state");
  cover property (run_test_active);
  cover property (!tdo_oe_n);
  cover property (high_reg == 3'h5);
endmodule // scan_tap_props
`default_nettype wire

//--- testbench/tap_master.sv
// test bus master model driving the serial test pins
`timescale 1ns/1ps
`default_nettype none
module tap_master (
  input  wire logic clock,
  input  wire logic tdo_out,
  input  wire logic tdo_oe_n,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 160 ns test clock; it stands low between calls
  task automatic pulse(input logic m, input logic d, output logic [1:0] seen);
    @(negedge clock);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clock);
    seen = {tdo_oe_n, tdo_out};
    tck = 1'b1;
    repeat (3) @(negedge clock);
    tck = 1'b0;
    tdi = 1'b1;
  endtask
  // shift n bits lsb first, leaving for exit1 on the last one
  task automatic scan(input logic [43:0] din, input int n, output logic [43:0] dout,
                      output logic oe_hi);
    logic [1:0] s;
    dout = 44'h0;
    oe_hi = 1'b0;
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], s);
      dout[i] = s[0];
      oe_hi = oe_hi | s[1];
    end
  endtask
endmodule // tap_master
`default_nettype wire

//--- testbench/scan_tap_test.sv
// self-checking bench for the test access port controller
`timescale 1ns/1ps
`default_nettype none
module scan_tap_test;
  localparam [31:0] ID = 32'h1357_9bdf; // arbitrary value
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        tck, tms, tdi, tdo_out, tdo_oe_n, oe_hi;
  logic        test_logic_reset, run_test_active, bsr_run_step;
  logic [43:0] bsr_capture = 44'h0;
  logic [43:0] bsr_update, dout;
  logic [7:0]  instruction;
  logic [2:0]  bcr_update;
  logic [1:0]  seen;
  int          bad_count = 0, checked = 0, cycles = 0, steps = 0;
  always #10 clock = ~clock;
  scan_tap #(.ID_CODE(ID)) i_scan_tap (
    .clock            (clock),
    .rst              (rst),
    .tck              (tck),
    .tms              (tms),
    .tdi              (tdi),
    .tdo_out          (tdo_out),
    .tdo_oe_n         (tdo_oe_n),
    .bsr_capture      (bsr_capture),
    .bsr_update       (bsr_update),
    .instruction      (instruction),
    .bcr_update       (bcr_update),
    .test_logic_reset (test_logic_reset),
    .run_test_active  (run_test_active),
    .bsr_run_step     (bsr_run_step)
  );
  tap_master i_tap_master (
    .clock    (clock),
    .tdo_out  (tdo_out),
    .tdo_oe_n (tdo_oe_n),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi)
  );
  always @(posedge clock) begin
    cycles++;
    if (bsr_run_step === 1'b1) steps++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [43:0] got, input logic [43:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic walk(input logic [4:0] path, input int n);
    for (int i = 0; i < n; i++) i_tap_master.pulse(path[i], 1'b1, seen);
  endtask
  task automatic t_reset;
    check("instruction", instruction, 8'h81);
    check("control", bcr_update, 3'h2);
    check("drive cells", bsr_update[43:40], 4'h0);
    check("reset flag", test_logic_reset, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_idcode;
    walk(5'b00010, 4);
    i_tap_master.scan(44'h0, 32, dout, oe_hi);
    check("id shift", dout[31:0], ID);
    check("oe in shift", oe_hi, 1'b0);
    walk(5'b00001, 1);
    check("oe after exit", seen[1], 1'b1);
    walk(5'b00000, 1);
    $display("id test done");
  endtask
  task automatic t_run;
    walk(5'b00011, 4);
    i_tap_master.scan(44'h09, 8, dout, oe_hi);
    check("ir capture", dout[7:0], 8'h81);
    walk(5'b00001, 2);
    check("new instruction", instruction, 8'h09);
    steps = 0;
    walk(5'b00000, 1);
    repeat (2) @(negedge clock);
    check("run steps", steps, 1);
    check("idle held", run_test_active, 1'b1);
    walk(5'b00001, 1);
    check("run stops", run_test_active, 1'b0);
    $display("run test done");
  endtask
  task automatic t_bypass;
    walk(5'b00001, 3);
    i_tap_master.scan(44'h55, 8, dout, oe_hi);
    walk(5'b00011, 4);
    i_tap_master.scan(44'h5, 4, dout, oe_hi);
    check("bypass path", dout[3:0], 4'ha);
    walk(5'b00001, 1);
    $display("bypass test done");
  endtask
  task automatic t_control;
    walk(5'b00011, 4);
    i_tap_master.scan(44'h0e, 8, dout, oe_hi);
    walk(5'b00011, 4);
    i_tap_master.scan(44'h5, 3, dout, oe_hi);
    check("control capture", dout[2:0], 3'h2);
    walk(5'b00001, 2);
    check("control update", bcr_update, 3'h5);
    $display("control test done");
  endtask
  task automatic t_sample;
    bsr_capture = 44'h9ab_cdef_1234;
    walk(5'b00011, 4);
    i_tap_master.scan(44'h82, 8, dout, oe_hi);
    walk(5'b00011, 4);
    i_tap_master.scan(44'h5f0_f0f0_0f0f, 44, dout, oe_hi);
    check("boundary capture", dout, 44'h9ab_cdef_1234);
    check("oe in boundary shift", oe_hi, 1'b0);
    walk(5'b00001, 2);
    check("boundary update", bsr_update, 44'h5f0_f0f0_0f0f);
    $display("sample test done");
  endtask
  task automatic t_five;
    walk(5'b11111, 5);
    check("forced reset", test_logic_reset, 1'b1);
    check("ir after reset", instruction, 8'h81);
    check("cells after reset", bsr_update[43:40], 4'h0);
    check("control after reset", bcr_update, 3'h2);
    $display("five high test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_idcode();
    t_run();
    t_bypass();
    t_control();
    t_sample();
    t_five();
    tally_and_finish();
  end
endmodule // scan_tap_test
bind scan_tap scan_tap_props #(.BSR_W(BSR_W)) i_scan_tap_props (
  .clock            (clock),
  .rst              (rst),
  .tck              (tck),
  .tms              (tms),
  .tdo_oe_n         (tdo_oe_n),
  .bsr_update       (bsr_update),
  .instruction      (instruction),
  .bcr_update       (bcr_update),
  .test_logic_reset (test_logic_reset),
  .run_test_active  (run_test_active),
  .bsr_run_step     (bsr_run_step)
);
`default_nettype wire
